// File: core/daq_command_status_regs.sv
/*
 * command register one, counter-2 enable and the read-only status word.
 * assumes host strobes are one-cycle pulses synchronous to clk, and that
 * fifo, counter and sequencer logic sit outside and use the control outputs.
 */
`timescale 1ns/1ps
`default_nettype none
module daq_command_status_regs
    import daq_regs_pkg::*;
(
    input  wire logic          clk,
    input  wire logic          nrst,
    input  wire logic [3:0]    bus_addr,
    input  wire logic          bus_wr,
    input  wire logic          bus_rd,
    input  wire logic          bus_word,
    input  wire logic [15:0]   bus_wdata,
    output logic      [15:0]   bus_rdata,
    input  wire logic          fifo_not_empty,
    input  wire logic [11:0]   fifo_raw,
    output logic      [15:0]   fifo_data_fmt,
    input  wire logic          sw_trigger,
    input  wire logic          start_trigger,
    input  wire logic          acq_done,
    input  wire logic          fifo_full_conv,
    input  wire logic          conv_overrun,
    input  wire logic          dma_tc_pulse,
    input  wire logic          counter_output_two,
    input  wire logic          conv_pulse,
    input  wire logic          counter1_out,
    input  wire analog_state_t analog_state,
    output logic               dma_request,
    output logic               counters_start,
    output logic               scan_step_enable,
    output logic               mux_clock,
    output logic               count_chain_32,
    output logic               acq_in_progress,
    output logic               irq
);
    logic [9:0] cmd_q;
    logic       cnt2_ie_q;
    logic       term_flag_q;
    logic       overflow_q;
    logic       overrun_q;
    logic       tc_flag_q;
    logic       cnt2_flag_q;
    logic       counter_output_two_prev_q;
    logic       counter_output_two_armed_q;
    logic       run_q;
    logic       run_d;
    logic [15:0] rdata_d;
    logic [15:0] fmt_d;
    cmd_one_t   cmd;
    logic [15:0] status_word;

    // host decode: word writes reach the command registers, any write reaches strobes
    wire wr_cmd1    = bus_wr && bus_word && bus_addr == OFS_CMD_STATUS;
    wire wr_cmd2    = bus_wr && bus_word && bus_addr == OFS_CMD_TWO;
    wire ai_clear   = bus_wr && bus_addr == OFS_AI_CLEAR;
    wire tc_clear   = bus_wr && bus_addr == OFS_DMA_TC_CLEAR;
    wire cnt2_clear = bus_wr && bus_addr == OFS_CNT2_CLEAR;
    wire rd_status  = bus_rd && bus_word && bus_addr == OFS_CMD_STATUS;

    // event decode
    wire trig       = sw_trigger || start_trigger;
    wire start_ok   = trig && cmd.acquisition_enable && !run_q;
    wire error_stop = fifo_full_conv || conv_overrun;
    wire stop_ev    = run_q && (acq_done || error_stop);
    wire counter_output_two_rise  = counter_output_two && !counter_output_two_prev_q && counter_output_two_armed_q;

    // interrupt sources gated by their enables
    wire term_irq   = term_flag_q && cmd.acq_termination_irq_enable;
    wire conv_irq   = fifo_not_empty && cmd.conversion_irq_enable;
    wire tc_irq     = tc_flag_q && cmd.terminal_count_irq_enable;
    wire cnt2_irq   = cnt2_flag_q && cnt2_ie_q;
    wire global_irq = term_irq || conv_irq || tc_irq || cnt2_irq;

    assign cmd = cmd_one_t'(cmd_q);

    // run state: start on an accepted trigger, end on completion or error
    always_comb begin
        run_d = run_q;
        if (start_ok) begin
            run_d = 1'b1;
        end
        if (stop_ev) begin
            run_d = 1'b0;
        end
    end

    // status word layout
    assign status_word = {global_irq,
                          term_flag_q,
                          fifo_not_empty,
                          cnt2_flag_q,
                          run_q,
                          tc_flag_q,
                          overflow_q,
                          overrun_q,
                          analog_state};

    // read data and formatted fifo data
    always_comb begin
        rdata_d = 16'h0000;
        if (rd_status) begin
            rdata_d = status_word;
        end
        if (cmd.data_format_select) begin
            fmt_d = {4'h0, fifo_raw};
        end else begin
            fmt_d = {{4{~fifo_raw[11]}}, fifo_raw ^ FMT_SIGN_BIT[11:0]};
        end
    end

    // command registers
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cmd_q     <= CMD_RESET[9:0];
            cnt2_ie_q <= 1'b0;
        end else begin
            if (wr_cmd1) begin
                cmd_q <= bus_wdata[9:0];
            end
            if (wr_cmd2) begin
                cnt2_ie_q <= bus_wdata[CMD2_CNT2_IE];
            end
        end
    end

    // sticky flag next values: a set in the clearing cycle wins
    wire term_flag_d = stop_ev || (term_flag_q && !ai_clear);
    wire overflow_d  = fifo_full_conv || (overflow_q && !ai_clear);
    wire overrun_d   = conv_overrun || (overrun_q && !ai_clear);
    wire tc_flag_d   = dma_tc_pulse || (tc_flag_q && !tc_clear);
    wire cnt2_flag_d = counter_output_two_rise || (cnt2_flag_q && !cnt2_clear);

    // termination flag: set by every run stop, normal or error
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            term_flag_q <= 1'b0;
        end else begin
            term_flag_q <= term_flag_d;
        end
    end

    // overflow flag: also set while idle, only a run is stopped by it
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            overflow_q <= 1'b0;
        end else begin
            overflow_q <= overflow_d;
        end
    end

    // overrun flag: same life cycle as the overflow flag
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            overrun_q <= 1'b0;
        end else begin
            overrun_q <= overrun_d;
        end
    end

    // dma terminal count flag, cleared by its own strobe
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tc_flag_q <= 1'b0;
        end else begin
            tc_flag_q <= tc_flag_d;
        end
    end

    // counter-2 edge flag, cleared by its own strobe
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt2_flag_q <= 1'b0;
        end else begin
            cnt2_flag_q <= cnt2_flag_d;
        end
    end

    // run state
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            run_q <= 1'b0;
        end else begin
            run_q <= run_d;
        end
    end

    // counter-2 edge history; the armed flop stops a pin already high at release
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            counter_output_two_prev_q  <= 1'b0;
            counter_output_two_armed_q <= 1'b0;
        end else begin
            counter_output_two_prev_q  <= counter_output_two;
            counter_output_two_armed_q <= 1'b1;
        end
    end

    // registered read data: status for one cycle after a status read, else zero
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            bus_rdata <= 16'h0000;
        end else begin
            bus_rdata <= rdata_d;
        end
    end

    // registered formatted fifo data, one cycle behind the raw code
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            fifo_data_fmt <= 16'h0000;
        end else begin
            fifo_data_fmt <= fmt_d;
        end
    end

    // control outputs to the acquisition datapath
    assign dma_request      = cmd.dma_request_enable && fifo_not_empty;
    assign counters_start   = start_ok;
    assign scan_step_enable = cmd.scan_enable;
    assign mux_clock        = cmd.scan_clock_divide ? counter1_out : conv_pulse;
    assign count_chain_32   = cmd.count_width_select;
    assign acq_in_progress  = run_q;
    assign irq              = global_irq;
endmodule
`default_nettype wire

// File: include/daq_regs_pkg.sv
/*
 * constants and carriers for the acquisition command and status register bank.
 * assumes a 16-bit host port with separate read and write strobes, one clock.
 */
// Behaviour
// - dma request when enabled and fifo holds data
// - triggers start counters only when acquisition enabled
// - scan enable steps mux-gain sequence, else fixed
// - scan divide takes mux clock from counter 1
// - count width: counter 4 alone or 4+5
// - format bit: straight binary or sign-extended
// - word read at offset 0 returns status
// - bit 15 shows pending board interrupt
// - bit 14 flags acquisition termination
// - analog clear write clears termination flag
// - bit 13 shows fifo not empty
// - conversion irq equals enable and not empty
// - bit 12 set on counter 2 rising edge
// - counter 2 clear strobe clears edge flag
// - word write at offset 0 loads command one
// - overflow sets flag, stops run, clear clears
// - overrun sets flag, stops run, clear clears
// - bit 11 shows acquisition in progress
package daq_regs_pkg;
    localparam logic [3:0] OFS_CMD_STATUS   = 4'h0;
    localparam logic [3:0] OFS_CMD_TWO      = 4'h2;
    localparam logic [3:0] OFS_AI_CLEAR     = 4'h8;
    localparam logic [3:0] OFS_DMA_TC_CLEAR = 4'hA;
    localparam logic [3:0] OFS_CNT2_CLEAR   = 4'hC;
    localparam int CMD_FMT      = 0;
    localparam int CMD_WIDTH    = 1;
    localparam int CMD_SCAN_CLOCK_DIVIDE  = 2;
    localparam int CMD_SCAN     = 3;
    localparam int CMD_ACQ      = 4;
    localparam int CMD_DMA      = 5;
    localparam int CMD_DUAL     = 6;
    localparam int CMD_CONV_IE  = 7;
    localparam int CMD_TC_IE    = 8;
    localparam int CMD_TERM_IE  = 9;
    localparam int CMD2_CNT2_IE = 0;
    localparam logic [15:0] CMD_RESET  = 16'h0000;
    localparam logic [15:0] FMT_SIGN_BIT = 16'h0800;

    typedef struct packed {
        logic        acq_termination_irq_enable;
        logic        terminal_count_irq_enable;
        logic        conversion_irq_enable;
        logic        dual_channel_dma_select;
        logic        dma_request_enable;
        logic        acquisition_enable;
        logic        scan_enable;
        logic        scan_clock_divide;
        logic        count_width_select;
        logic        data_format_select;
    } cmd_one_t;

    typedef struct packed {
        logic [1:0] gain;
        logic       active_dma_channel;
        logic       upper_mux_enabled;
        logic       lower_mux_enabled;
        logic [2:0] channel_address;
    } analog_state_t;
endpackage

// File: testbench/daq_regs_monitor.sv
/* port assertions for the command and status bank.
   assumes one clk domain, async low nrst, bound to the top. */
`timescale 1ns/1ps
`default_nettype none
module daq_regs_monitor
    import daq_regs_pkg::*;
(
    input wire logic        clk,
    input wire logic        nrst,
    input wire logic [3:0]  bus_addr,
    input wire logic        bus_wr,
    input wire logic        bus_rd,
    input wire logic        bus_word,
    input wire logic [15:0] bus_wdata,
    input wire logic [15:0] bus_rdata,
    input wire logic        fifo_not_empty,
    input wire logic        conv_overrun,
    input wire logic        dma_request,
    input wire logic        counters_start,
    input wire logic        scan_step_enable,
    input wire logic        count_chain_32,
    input wire logic        acq_in_progress,
    input wire logic        irq
);
    logic [15:0] cmd_q;
    // shadow of command one, loaded by word writes at offset 0
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) cmd_q <= CMD_RESET;
        else if (bus_wr && bus_word && bus_addr == OFS_CMD_STATUS) cmd_q <= bus_wdata;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence s_status_rd;
        bus_rd && bus_word && bus_addr == OFS_CMD_STATUS;
    endsequence
    chk_dma_gate: assert property (dma_request == (cmd_q[CMD_DMA] && fifo_not_empty))
        else $error("dma request mismatch");
    chk_start_gate: assert property (counters_start |-> cmd_q[CMD_ACQ])
        else $error("start without enable");
    chk_scan_mode: assert property (scan_step_enable == cmd_q[CMD_SCAN])
        else $error("scan enable mismatch");
    chk_count_width: assert property (count_chain_32 == cmd_q[CMD_WIDTH])
        else $error("count width mismatch");
    chk_conv_irq: assert property (cmd_q[CMD_CONV_IE] && fifo_not_empty |-> irq)
        else $error("conversion irq missing");
    chk_run_start: assert property (counters_start |=> acq_in_progress)
        else $error("run did not start");
    chk_overrun_stop: assert property (acq_in_progress && conv_overrun |=> !acq_in_progress)
        else $error("run did not stop");
    chk_status_read: assert property (s_status_rd |=> bus_rdata[15] == $past(irq))
        else $error("status irq bit mismatch");
endmodule
`default_nettype wire
bind daq_command_status_regs daq_regs_monitor u_mon (.*);

// File: testbench/fifo_side_model.sv
/* fifo occupancy stand-in for the far side of the bank.
   assumes push and pop pulses driven on clk by the bench. */
`timescale 1ns/1ps
`default_nettype none
module fifo_side_model (
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic push,
    input  wire logic pop,
    output logic      not_empty
);
    logic [1:0] fill_q;
    // a pop on an empty fifo is dropped
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) fill_q <= 2'h0;
        else fill_q <= fill_q + 2'(push) - 2'(pop && fill_q != 2'h0);
    end
    assign not_empty = fill_q != 2'h0;
endmodule
`default_nettype wire

// File: testbench/testbench.sv
/* self-checking bench for the command and status bank.
   assumes the fifo side model and the bound monitor. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import daq_regs_pkg::*;
    logic        clk, nrst, wr, rd, push, pop, c2, word;
    logic [3:0]  addr;
    logic [5:0]  ev;
    logic [11:0] raw;
    logic [15:0] wd, rdata, fmt;
    logic        ne, dreq, cst, c32, run, irq, scn, mclk;
    int          err_total, num_checks;
    fifo_side_model u_fifo (.clk, .nrst, .push, .pop, .not_empty(ne));
    daq_command_status_regs u_dut (.clk, .nrst, .bus_addr(addr), .bus_wr(wr), .bus_rd(rd),
        .bus_word(word), .bus_wdata(wd), .bus_rdata(rdata), .fifo_not_empty(ne),
        .fifo_raw(raw), .fifo_data_fmt(fmt), .sw_trigger(ev[0]), .start_trigger(ev[1]),
        .acq_done(ev[2]), .fifo_full_conv(ev[3]), .conv_overrun(ev[4]),
        .dma_tc_pulse(ev[5]), .counter_output_two(c2), .conv_pulse(push),
        .counter1_out(pop), .analog_state(8'hA5), .dma_request(dreq), .counters_start(cst),
        .scan_step_enable(scn), .mux_clock(mclk), .count_chain_32(c32),
        .acq_in_progress(run), .irq);
    always #4 clk = ~clk;
    task automatic chk(string n, logic [15:0] e, logic [15:0] g);
        num_checks++;
        if (e !== g) begin
            err_total++;
            $display("wrong value %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic wreg(logic [3:0] a, logic [15:0] d);
        @(negedge clk);
        addr = a;
        wd = d;
        wr = 1;
        @(negedge clk);
        wr = 0;
    endtask
    // status read; low byte is the analog state
    task automatic st(logic [15:0] e);
        @(negedge clk);
        addr = 4'h0;
        rd = 1;
        @(negedge clk);
        rd = 0;
        chk("status", e | 16'h00A5, rdata);
    endtask
    task automatic fire(int i);
        @(negedge clk);
        ev = 6'(1 << i);
    endtask
    task automatic t_dma();
        wreg(4'h0, 16'h00A0);
        push = 1;
        @(negedge clk);
        push = 0;
        chk("dma_request", 1, dreq);
        st(16'hA000);
        pop = 1;
        @(negedge clk);
        pop = 0;
        chk("irq", 0, irq);
        // a byte write at offset 0 leaves command one alone
        word = 0;
        wreg(4'h0, 16'h0000);
        word = 1;
        push = 1;
        @(negedge clk);
        push = 0;
        chk("dma_request", 1, dreq);
        wreg(4'h0, 16'h0000);
        chk("dma_request", 0, dreq);
        chk("irq", 0, irq);
        st(16'h2000);
        pop = 1;
        @(negedge clk);
        pop = 0;
    endtask
    // mux clock follows the conversion pulse, or counter 1 when divided
    task automatic t_mux();
        wreg(4'h0, 16'h0004);
        chk("scan_step_enable", 0, scn);
        pop = 1;
        #1 chk("mux_clock", 1, mclk);
        @(negedge clk);
        {pop, push} = 2'b01;
        #1 chk("mux_clock", 0, mclk);
        @(negedge clk);
        push = 0;
        wreg(4'h0, 16'h0000);
        push = 1;
        #1 chk("mux_clock", 1, mclk);
        @(negedge clk);
        {push, pop} = 2'b01;
        #1 chk("mux_clock", 0, mclk);
        repeat (2) @(negedge clk);
        pop = 0;
    endtask
    // reset in mid-run with counter output 2 held high: no false edge after release
    task automatic t_reset();
        wreg(4'h0, 16'h0210);
        fire(0);
        @(negedge clk);
        ev = 0;
        chk("run", 1, run);
        nrst = 0;
        repeat (2) @(negedge clk);
        nrst = 1;
        chk("run", 0, run);
        chk("dma_request", 0, dreq);
        st(16'h0000);
    endtask
    // start by either trigger, stop by done, overflow or overrun
    task automatic t_run();
        for (int k = 2; k < 5; k++) begin
            wreg(4'h0, 16'h0210);
            fire(k % 2);
            #1 chk("start", 1, cst);
            fire(k);
            chk("run", 1, run);
            @(negedge clk);
            ev = 0;
            chk("run", 0, run);
            st(16'hC000 | ((k == 2) ? 16'h0000 : 16'h0400 >> (k - 2)));
            wreg(4'h8, 16'h0000);
            st(16'h0000);
        end
        wreg(4'h0, 16'h0000);
        fire(0);
        #1 chk("start", 0, cst);
        @(negedge clk);
        ev = 0;
    endtask
    task automatic t_cnt2();
        c2 = 1;
        st(16'h1000);
        wreg(4'h2, 16'h0001);
        st(16'h9000);
        wreg(4'hC, 16'h0000);
        st(16'h0000);
    endtask
    task automatic t_fmt();
        logic [15:0] ex [4] = '{16'hF800, 16'h07FF, 16'h0000, 16'h0FFF};
        for (int f = 0; f < 2; f++) begin
            wreg(4'h0, 16'h000A | 16'(f));
            chk("count_chain_32", 1, c32);
            chk("scan_step_enable", 1, scn);
            for (int j = 0; j < 2; j++) begin
                raw = (j != 0) ? 12'hFFF : 12'h000;
                @(negedge clk);
                chk("fifo_data_fmt", ex[f * 2 + j], fmt);
            end
        end
    endtask
    task automatic final_report();
        if (err_total == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        {clk, nrst, wr, rd, push, pop, c2} = 7'h00;
        word = 1;
        {ev, addr, raw, wd} = 38'h0;
        repeat (12) @(negedge clk);
        nrst = 1;
        st(16'h0000);
        t_dma();
        t_mux();
        t_run();
        t_cnt2();
        t_reset();
        t_fmt();
        final_report();
    end
    // watchdog against a hung run
    initial begin
        #100000;
        err_total++;
        final_report();
    end
endmodule
`default_nettype wire
